//--- rtl/entry_count_rebuild.sv
// Rebuilds a linear buffer entry count from its three descriptor slices.
// Assumes the caller has already masked the depth slice to the width the buffer kind uses.
`timescale 1ns/10ps

module entry_count_rebuild #(
    parameter int DEPTH_SLICE_W = 10,
    parameter int HEIGHT_SLICE_W = 14,
    parameter int WIDTH_SLICE_W = 7
)
(
    // Slices of the entry count minus one
    input wire logic [DEPTH_SLICE_W-1:0] depthSlice,
    input wire logic [HEIGHT_SLICE_W-1:0] heightSlice,
    input wire logic [WIDTH_SLICE_W-1:0] widthSlice,
    // Rebuilt count, one wider than the joined slices
    output logic [DEPTH_SLICE_W+HEIGHT_SLICE_W+WIDTH_SLICE_W:0] entryCount
);

    localparam int JOIN_W = DEPTH_SLICE_W + HEIGHT_SLICE_W + WIDTH_SLICE_W;

    logic [JOIN_W-1:0] entryMinusOne;

    // Join slices, most significant first
    assign entryMinusOne = {depthSlice, heightSlice, widthSlice};

    // Add one with a carry bit so the top count does not wrap
    assign entryCount = {1'b0, entryMinusOne} + {{JOIN_W{1'b0}}, 1'b1};

endmodule

//--- rtl/surface_height_field_decode.sv
// Surface height field decoder with a classic Wishbone register slave.
// Software loads descriptor words two and three plus a control word; the decoded
// row counts and buffer entry count are held in flops for the consumers.
// Assumes a single 100 MHz clock and a master that keeps its request until ack.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps

module surface_height_field_decode #(
    parameter int ADR_W = 8
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Decoded result
    output surface_height_pkg::decode_t decoded
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [surface_height_pkg::CTRL_KIND_W-1:0] kindSel;
    logic rawFormat;
    logic lineStride;
    logic [surface_height_pkg::CTRL_LOD_W-1:0] lodSelect;
    logic [31:0] descWord2;
    logic [31:0] descWord3;
    logic busRequest;
    logic writeStrobe;
    logic [5:0] wordIndex;
    surface_height_pkg::surface_kind_t kind;
    logic [surface_height_pkg::HEIGHT_W-1:0] heightField;
    logic [surface_height_pkg::WIDTH_W-1:0] widthField;
    logic [surface_height_pkg::DEPTH_W-1:0] depthField;
    logic [surface_height_pkg::DEPTH_RAW_W-1:0] depthSlice;
    logic [surface_height_pkg::ENTRY_W-1:0] rebuiltCount;
    surface_height_pkg::decode_t next_decoded;
    logic [31:0] next_readData;

    // Byte-lane merge for register writes
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldValue, input logic [31:0] newValue,
                                               input logic [3:0] sel);
        logic [31:0] mask;
        mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        mergeBytes = (oldValue & ~mask) | (newValue & mask);
    endfunction

    // ****************************************
    // Wishbone handshake
    // ****************************************

    // One request per access, ack dropped the cycle after it is given
    assign busRequest = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign writeStrobe = busRequest & wb_we_i;
    assign wordIndex = wb_adr_i[7:2];

    // Registered acknowledge
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= busRequest;
        end
    end

    // ****************************************
    // Writable registers
    // ****************************************

    // Control word: surface kind, raw format, line skip, level select
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            kindSel <= surface_height_pkg::KIND_RESET;
            rawFormat <= 1'b0;
            lineStride <= 1'b0;
            lodSelect <= '0;
        end
        else if (writeStrobe && wordIndex == surface_height_pkg::CTRL_OFFSET[7:2])
        begin
            if (wb_sel_i[0])
            begin
                kindSel <= wb_dat_i[surface_height_pkg::CTRL_KIND_LSB +: surface_height_pkg::CTRL_KIND_W];
                rawFormat <= wb_dat_i[surface_height_pkg::CTRL_RAW_BIT];
                lineStride <= wb_dat_i[surface_height_pkg::CTRL_STRIDE_BIT];
                lodSelect[2:0] <= wb_dat_i[surface_height_pkg::CTRL_LOD_LSB +: 3];
            end
            if (wb_sel_i[1])
            begin
                lodSelect[3] <= wb_dat_i[surface_height_pkg::CTRL_LOD_LSB + 3];
            end
        end
    end

    // Descriptor word two, holding height and width
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            descWord2 <= surface_height_pkg::DESC_RESET;
        end
        else if (writeStrobe && wordIndex == surface_height_pkg::DESC_WORD2_OFFSET[7:2])
        begin
            descWord2 <= mergeBytes(descWord2, wb_dat_i, wb_sel_i);
        end
    end

    // Descriptor word three, holding depth
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            descWord3 <= surface_height_pkg::DESC_RESET;
        end
        else if (writeStrobe && wordIndex == surface_height_pkg::DESC_WORD3_OFFSET[7:2])
        begin
            descWord3 <= mergeBytes(descWord3, wb_dat_i, wb_sel_i);
        end
    end

    // ****************************************
    // Field extraction
    // ****************************************

    // Height field, unsigned 14 bits
    assign heightField = descWord2[surface_height_pkg::HEIGHT_MSB:surface_height_pkg::HEIGHT_LSB];
    assign widthField = descWord2[surface_height_pkg::WIDTH_MSB:surface_height_pkg::WIDTH_LSB];
    assign depthField = descWord3[surface_height_pkg::DEPTH_MSB:surface_height_pkg::DEPTH_LSB];
    assign kind = surface_height_pkg::surface_kind_t'(kindSel);

    // Depth slice masked to the width each buffer kind uses
    always_comb
    begin
        depthSlice = '0;
        case (kind)
            surface_height_pkg::TYPED_LINEAR_BUFFER_KIND:
            begin
                if (rawFormat)
                begin
                    depthSlice = depthField[surface_height_pkg::DEPTH_RAW_W-1:0];
                end
                else
                begin
                    depthSlice = {3'h0, depthField[surface_height_pkg::DEPTH_TYPED_W-1:0]};
                end
            end
            surface_height_pkg::STRUCTURED_LINEAR_BUFFER_KIND:
            begin
                depthSlice = {4'h0, depthField[surface_height_pkg::DEPTH_STRUCT_W-1:0]};
            end
            default:
            begin
                depthSlice = '0;
            end
        endcase
    end

    // Entry count rebuild from depth, height and width slices
    entry_count_rebuild #(
        .DEPTH_SLICE_W(surface_height_pkg::DEPTH_RAW_W),
        .HEIGHT_SLICE_W(surface_height_pkg::HEIGHT_W),
        .WIDTH_SLICE_W(surface_height_pkg::WIDTH_BUF_W)
    ) entryRebuild (
        .depthSlice(depthSlice),
        .heightSlice(heightField),
        .widthSlice(widthField[surface_height_pkg::WIDTH_BUF_W-1:0]),
        .entryCount(rebuiltCount)
    );

    // ****************************************
    // Decode
    // ****************************************

    // Row counts, buffer count and descriptor faults
    always_comb
    begin
        next_decoded = '0;
        next_decoded.reservedFault = (descWord2[31:30] != 2'h0) | (descWord2[15:14] != 2'h0);
        case (kind)
            surface_height_pkg::SINGLE_ROW_SURFACE_KIND:
            begin
                next_decoded.baseRows = 15'h0001;
                next_decoded.heightFault = (heightField != '0);
            end
            surface_height_pkg::PLANAR_SURFACE_KIND,
            surface_height_pkg::VOLUME_SURFACE_KIND,
            surface_height_pkg::SIX_FACE_SURFACE_KIND:
            begin
                // Field is rows minus one of the base level
                next_decoded.baseRows = {1'b0, heightField} + 15'h0001;
            end
            surface_height_pkg::TYPED_LINEAR_BUFFER_KIND:
            begin
                next_decoded.isBuffer = 1'b1;
                next_decoded.entryCount = rebuiltCount;
                next_decoded.entryIsBytes = rawFormat;
                // Unused upper bits are expected to be zero
                if (rawFormat)
                begin
                    next_decoded.unusedFault = (widthField[13:7] != 7'h00) | depthField[10];
                end
                else
                begin
                    next_decoded.unusedFault = (widthField[13:7] != 7'h00) | (depthField[10:7] != 4'h0);
                end
            end
            surface_height_pkg::STRUCTURED_LINEAR_BUFFER_KIND:
            begin
                next_decoded.isBuffer = 1'b1;
                next_decoded.entryCount = rebuiltCount;
                next_decoded.unusedFault = (widthField[13:7] != 7'h00) | (depthField[10:6] != 5'h00);
            end
            default:
            begin
                next_decoded.kindFault = 1'b1;
            end
        endcase
        // Rows of the selected detail level, never below one for image kinds
        next_decoded.lodRows = next_decoded.baseRows >> lodSelect;
        if (next_decoded.lodRows == '0 && !next_decoded.isBuffer && !next_decoded.kindFault)
        begin
            next_decoded.lodRows = 15'h0001;
        end
        // Height is one field when lines are skipped, so the frame is twice as tall
        if (lineStride)
        begin
            next_decoded.frameRows = {next_decoded.baseRows, 1'b0};
        end
        else
        begin
            next_decoded.frameRows = {1'b0, next_decoded.baseRows};
        end
    end

    // Result held in flops for the consumers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            decoded <= '0;
        end
        else
        begin
            decoded <= next_decoded;
        end
    end

    // ****************************************
    // Read path
    // ****************************************

    // Read multiplexer, zero on unmapped words
    always_comb
    begin
        next_readData = 32'h0000_0000;
        case (wordIndex)
            surface_height_pkg::CTRL_OFFSET[7:2]:
            begin
                next_readData[surface_height_pkg::CTRL_KIND_LSB +: surface_height_pkg::CTRL_KIND_W] = kindSel;
                next_readData[surface_height_pkg::CTRL_RAW_BIT] = rawFormat;
                next_readData[surface_height_pkg::CTRL_STRIDE_BIT] = lineStride;
                next_readData[surface_height_pkg::CTRL_LOD_LSB +: surface_height_pkg::CTRL_LOD_W] = lodSelect;
            end
            surface_height_pkg::DESC_WORD2_OFFSET[7:2]:
            begin
                next_readData = descWord2;
            end
            surface_height_pkg::DESC_WORD3_OFFSET[7:2]:
            begin
                next_readData = descWord3;
            end
            surface_height_pkg::STATUS_OFFSET[7:2]:
            begin
                next_readData[surface_height_pkg::STAT_HEIGHT_FAULT_BIT] = decoded.heightFault;
                next_readData[surface_height_pkg::STAT_UNUSED_FAULT_BIT] = decoded.unusedFault;
                next_readData[surface_height_pkg::STAT_IS_BUFFER_BIT] = decoded.isBuffer;
                next_readData[surface_height_pkg::STAT_KIND_FAULT_BIT] = decoded.kindFault;
                next_readData[surface_height_pkg::STAT_RESERVED_FAULT_BIT] = decoded.reservedFault;
                next_readData[surface_height_pkg::STAT_BYTES_BIT] = decoded.entryIsBytes;
            end
            surface_height_pkg::ROWS_OFFSET[7:2]:
            begin
                next_readData[surface_height_pkg::ROWS_W-1:0] = decoded.baseRows;
                next_readData[surface_height_pkg::ROWS_LOD_LSB +: surface_height_pkg::ROWS_W] = decoded.lodRows;
            end
            surface_height_pkg::FRAME_OFFSET[7:2]:
            begin
                next_readData[surface_height_pkg::ROWS_W:0] = decoded.frameRows;
            end
            surface_height_pkg::ENTRY_OFFSET[7:2]:
            begin
                next_readData = decoded.entryCount;
            end
            default:
            begin
                next_readData = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured with the acknowledge
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (busRequest && !wb_we_i)
        begin
            wb_dat_o <= next_readData;
        end
    end

endmodule

//--- rtl/surface_height_pkg.sv
// Package for the surface height field decoder.
// Holds register offsets, descriptor field positions, surface kinds and the decoded result.
// Assumes a 32-bit classic Wishbone bus with byte-aligned word registers.
package surface_height_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DESC_WORD2_OFFSET = 8'h04;
    localparam logic [7:0] DESC_WORD3_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;
    localparam logic [7:0] ROWS_OFFSET = 8'h10;
    localparam logic [7:0] FRAME_OFFSET = 8'h14;
    localparam logic [7:0] ENTRY_OFFSET = 8'h18;

    // ****************************************
    // Control register layout
    // ****************************************
    localparam int CTRL_KIND_LSB = 0;
    localparam int CTRL_KIND_W = 3;
    localparam int CTRL_RAW_BIT = 3;
    localparam int CTRL_STRIDE_BIT = 4;
    localparam int CTRL_LOD_LSB = 5;
    localparam int CTRL_LOD_W = 4;

    // ****************************************
    // Status register layout
    // ****************************************
    localparam int STAT_HEIGHT_FAULT_BIT = 0;
    localparam int STAT_UNUSED_FAULT_BIT = 1;
    localparam int STAT_IS_BUFFER_BIT = 2;
    localparam int STAT_KIND_FAULT_BIT = 3;
    localparam int STAT_RESERVED_FAULT_BIT = 4;
    localparam int STAT_BYTES_BIT = 5;
    localparam int ROWS_LOD_LSB = 16;

    // ****************************************
    // Descriptor field positions
    // ****************************************
    localparam int HEIGHT_MSB = 29;
    localparam int HEIGHT_LSB = 16;
    localparam int HEIGHT_W = 14;
    localparam int WIDTH_MSB = 13;
    localparam int WIDTH_LSB = 0;
    localparam int WIDTH_W = 14;
    localparam int WIDTH_BUF_W = 7;
    localparam int DEPTH_MSB = 31;
    localparam int DEPTH_LSB = 21;
    localparam int DEPTH_W = 11;
    localparam int DEPTH_RAW_W = 10;
    localparam int DEPTH_TYPED_W = 7;
    localparam int DEPTH_STRUCT_W = 6;
    localparam int ROWS_W = 15;
    localparam int ENTRY_W = 32;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] DESC_RESET = 32'h0000_0000;
    localparam logic [CTRL_KIND_W-1:0] KIND_RESET = 3'h1;

    // Surface kinds
    typedef enum logic [2:0]
    {
        SINGLE_ROW_SURFACE_KIND = 3'h0,
        PLANAR_SURFACE_KIND = 3'h1,
        VOLUME_SURFACE_KIND = 3'h2,
        SIX_FACE_SURFACE_KIND = 3'h3,
        TYPED_LINEAR_BUFFER_KIND = 3'h4,
        STRUCTURED_LINEAR_BUFFER_KIND = 3'h5
    } surface_kind_t;

    // Decoded result for the sampling and data-port consumers
    typedef struct packed
    {
        logic [ROWS_W-1:0] baseRows;
        logic [ROWS_W-1:0] lodRows;
        logic [ROWS_W:0] frameRows;
        logic [ENTRY_W-1:0] entryCount;
        logic isBuffer;
        logic entryIsBytes;
        logic heightFault;
        logic unusedFault;
        logic kindFault;
        logic reservedFault;
    } decode_t;

endpackage

//--- tb/descriptor_software_model.sv
// Driver software model: builds buffer descriptors and drives classic Wishbone cycles.
// Assumes one clock; every request change lands by non-blocking assignment after a rising edge.
`timescale 1ns/10ps

module descriptor_software_model
(
    // Clock
    input wire logic clk,
    // Wishbone master side
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [7:0] adr,
    output logic [3:0] sel,
    output logic [31:0] dat,
    input wire logic ack,
    input wire logic [31:0] rdat
);
    // Idle bus at time zero
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'hffff_ffff;
    end

    // One classic cycle, held until ack is sampled high
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        dat <= ~d; // Released data does not keep its last value
    endtask

    task automatic wb_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        wb_cycle(1'b1, a, d, s, r);
    endtask

    task automatic wb_read(input logic [7:0] a, output logic [31:0] r);
        wb_cycle(1'b0, a, 32'h0, 4'hf, r);
    endtask

    // Split count minus one right-justified over height, width and depth
    function automatic void build_buffer(input logic [31:0] count, output logic [31:0] d2, output logic [31:0] d3);
        logic [31:0] n;
        n = count - 32'h1;
        d2 = {2'b00, n[20:7], 9'h000, n[6:0]};
        d3 = {n[31:21], 21'h0};
    endfunction
endmodule

//--- tb/surface_height_field_decode_assertions.sv
// Checker for the surface height decoder, watching only the top module ports.
// Assumes the single clk_sys domain with rst active high.
`timescale 1ns/10ps

module surface_height_field_decode_checker #(
    parameter int ADR_W = 8
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Decoded result
    input wire surface_height_pkg::decode_t decoded
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ****************************************
    // Properties
    // ****************************************
    property p_ackOnce;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ackOnce: assert property (p_ackOnce) else $error("ack longer than one cycle");
    property p_ackTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ackTaken: assert property (p_ackTaken) else $error("request not acked next cycle");
    property p_ackCause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ackCause: assert property (p_ackCause) else $error("ack without request");
    property p_reserved;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h01 && wb_sel_i[3]
            && wb_dat_i[31:30] != 2'b00 |-> ##2 decoded.reservedFault;
    endproperty
    a_reserved: assert property (p_reserved) else $error("bits above the height not flagged");
    property p_imageRows;
        !$past(rst) && !decoded.isBuffer && !decoded.kindFault |-> decoded.baseRows != 0 && decoded.lodRows != 0;
    endproperty
    a_imageRows: assert property (p_imageRows) else $error("image rows zero");
    property p_bufRows;
        decoded.isBuffer |-> decoded.baseRows == 0 && decoded.lodRows == 0;
    endproperty
    a_bufRows: assert property (p_bufRows) else $error("buffer given rows");
    property p_lodBase;
        decoded.lodRows <= decoded.baseRows;
    endproperty
    a_lodBase: assert property (p_lodBase) else $error("level rows above base rows");
    property p_frame;
        decoded.frameRows == {1'b0, decoded.baseRows} || decoded.frameRows == {decoded.baseRows, 1'b0};
    endproperty
    a_frame: assert property (p_frame) else $error("frame rows not base or twice base");
    property p_entry;
        decoded.isBuffer == (decoded.entryCount != 32'h0);
    endproperty
    a_entry: assert property (p_entry) else $error("entry count and buffer flag disagree");
    property p_bytes;
        decoded.entryIsBytes |-> decoded.isBuffer;
    endproperty
    a_bytes: assert property (p_bytes) else $error("byte sizing outside buffer");

    // Main scenarios reached
    c_buffer: cover property (decoded.isBuffer);
    c_bytes: cover property (decoded.entryIsBytes);
    c_field: cover property (decoded.frameRows > {1'b0, decoded.baseRows});
endmodule

bind surface_height_field_decode surface_height_field_decode_checker #(.ADR_W(ADR_W)) chk (.clk_sys(clk_sys),
    .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .decoded(decoded));

//--- tb/surface_height_field_decode_bench.sv
// Self-checking bench for the surface height decoder.
// Assumes the software model drives the bus; expectations come from bench functions.
`timescale 1ns/10ps

module surface_height_field_decode_bench;
    logic clkSys, rst, wbCyc, wbStb, wbWe, wbAck;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR, rd, d2, d3;
    surface_height_pkg::decode_t decoded;
    int num_errors = 0;
    int checks = 0;
    int i;
    logic [2:0] k;
    logic rw, st;
    logic [3:0] lod;

    surface_height_field_decode DUT (.clk_sys(clkSys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .decoded(decoded));
    descriptor_software_model drv (.clk(clkSys), .cyc(wbCyc), .stb(wbStb), .we(wbWe), .adr(wbAdr),
        .sel(wbSel), .dat(wbDatW), .ack(wbAck), .rdat(wbDatR));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Expected status word from kind, raw flag and descriptor words
    function automatic logic [31:0] exp_status(input logic [2:0] kd, input logic raw, input logic [31:0] w2,
                                              input logic [31:0] w3);
        logic isb;
        logic [10:0] dm;
        isb = (kd == 3'h4) || (kd == 3'h5);
        dm = (kd == 3'h5) ? 11'h03f : (raw ? 11'h3ff : 11'h07f);
        exp_status = {26'h0, isb && raw && kd == 3'h4, w2[31:30] != 2'b00 || w2[15:14] != 2'b00,
                      kd > 3'h5, isb, isb && (w2[13:7] != 7'h0 || (w3[31:21] & ~dm) != 11'h0),
                      kd == 3'h0 && w2[29:16] != 14'h0};
    endfunction

    // Load one descriptor and compare every decoded register
    task automatic run_case(input logic [2:0] kd, input logic raw, input logic str, input logic [3:0] lv,
                            input logic [31:0] w2, input logic [31:0] w3);
        logic [14:0] base, lr;
        logic [13:0] h;
        logic [10:0] dm;
        logic isb;
        h = w2[29:16];
        isb = (kd == 3'h4) || (kd == 3'h5);
        dm = (kd == 3'h5) ? 11'h03f : (raw ? 11'h3ff : 11'h07f);
        base = (kd == 3'h0) ? 15'h1 : ((kd < 3'h4) ? {1'b0, h} + 15'h1 : 15'h0);
        lr = base >> lv;
        if (kd < 3'h4 && lr == 15'h0)
            lr = 15'h1;
        drv.wb_write(8'h00, {23'h0, lv, str, raw, kd}, 4'hf);
        drv.wb_write(8'h04, w2, 4'hf);
        drv.wb_write(8'h08, w3, 4'hf);
        drv.wb_read(8'h00, rd);
        check(rd, {23'h0, lv, str, raw, kd});
        drv.wb_read(8'h0c, rd);
        check(rd, exp_status(kd, raw, w2, w3));
        drv.wb_read(8'h10, rd);
        check(rd, {1'b0, lr, 1'b0, base});
        drv.wb_read(8'h14, rd);
        check(rd, {16'h0, str ? {base, 1'b0} : {1'b0, base}});
        drv.wb_read(8'h18, rd);
        check(rd, isb ? {w3[31:21] & dm, h, w2[6:0]} + 32'h1 : 32'h0);
    endtask

    // Clock
    initial
    begin
        clkSys = 1'b0;
        forever #5 clkSys = ~clkSys;
    end

    // Watchdog
    initial
    begin
        repeat (30000) @(posedge clkSys);
        num_errors++;
        complete_run;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        void'($urandom(32'h74b8));
        repeat (2) @(posedge clkSys);
        rst <= 1'b0;
        // Reset state, read-only and unmapped places
        drv.wb_write(8'h0c, 32'hffff_ffff, 4'hf);
        drv.wb_write(8'h1c, 32'hffff_ffff, 4'hf);
        drv.wb_read(8'h0c, rd);
        check(rd, 32'h0);
        drv.wb_read(8'h10, rd);
        check(rd, 32'h0001_0001);
        drv.wb_read(8'h1c, rd);
        check(rd, 32'h0);
        // Upper lanes only reach the height
        drv.wb_write(8'h04, 32'h0005_ffff, 4'hc);
        drv.wb_read(8'h10, rd);
        check(rd, 32'h0006_0006);
        // Corner cases
        run_case(3'h1, 1'b0, 1'b0, 4'h0, 32'h3fff_0000, 32'h0);
        run_case(3'h2, 1'b0, 1'b1, 4'hf, 32'h3fff_0000, 32'h0);
        run_case(3'h3, 1'b0, 1'b1, 4'h3, 32'h0000_0000, 32'h0);
        run_case(3'h0, 1'b0, 1'b0, 4'h0, 32'h0001_0000, 32'h0);
        run_case(3'h6, 1'b0, 1'b0, 4'h0, 32'h0001_0000, 32'h0);
        run_case(3'h7, 1'b1, 1'b1, 4'h2, 32'hc000_c000, 32'h0);
        drv.build_buffer(32'h0800_0000, d2, d3);
        run_case(3'h4, 1'b0, 1'b0, 4'h0, d2, d3);
        run_case(3'h5, 1'b0, 1'b0, 4'h0, d2, d3);
        drv.build_buffer(32'h4000_0000, d2, d3);
        run_case(3'h4, 1'b1, 1'b0, 4'h0, d2, d3);
        drv.build_buffer(32'h1, d2, d3);
        run_case(3'h5, 1'b0, 1'b1, 4'h1, d2, d3);
        // Random descriptors, with forbidden bits now and then
        for (i = 0; i < 48; i++)
        begin
            k = 3'($urandom % 8);
            rw = 1'($urandom % 2);
            st = 1'($urandom % 2);
            lod = 4'($urandom % 16);
            if (k == 3'h4 || k == 3'h5)
                drv.build_buffer((k == 3'h4 && rw) ? ($urandom % 32'h4000_0000) + 32'h1
                                                   : ($urandom % 32'h0800_0000) + 32'h1, d2, d3);
            else
            begin
                d2 = $urandom;
                d3 = $urandom;
                if (i % 4 != 0)
                    d2 = d2 & 32'h3fff_3fff;
            end
            if (i % 8 == 7)
                d2[13] = 1'b1;
            run_case(k, rw, st, lod, d2, d3);
        end
        complete_run;
    end
endmodule
